// *** pfm_pkg.sv ***
// Constants, register map and carrier types for the failure monitor.
// Assumes a 10 MHz core clock and a single AHB-Lite master.
package pfm_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int SCHED_HOURS = 2;
  localparam int SCHED_MS = SCHED_HOURS * 3600 * 1000 / TICK_MS;
  localparam int ONLINE_DELAY_MS = 42;
  localparam int FULL_DELAY_MS = 163;
  localparam logic [7:0] ONLINE_LIMIT = 8'(ONLINE_DELAY_MS / TICK_MS);
  localparam logic [7:0] FULL_LIMIT = 8'(FULL_DELAY_MS / TICK_MS);

  // ----------------------------------------------------------------
  // Register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_TIMER = 8'h0C;
  localparam logic [7:0] A_SENSE = 8'h10;
  localparam logic [7:0] A_ERRCNT = 8'h14;
  localparam logic [7:0] A_HIST = 8'h18;
  localparam int CTRL_DEXC = 0;
  localparam int CTRL_ONLINE = 1;
  localparam int CTRL_METHOD = 4;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int CMD_RZ = 0;
  localparam int CMD_ACK = 1;
  localparam logic [7:0] LOG_TIMER_PAGE = 8'h3E;

  // ----------------------------------------------------------------
  // Sense codes
  // ----------------------------------------------------------------
  localparam logic [7:0] SK_RECOVERED = 8'h01;
  localparam logic [7:0] SK_MEDIUM = 8'h03;
  localparam logic [7:0] SK_HW = 8'h04;
  localparam logic [7:0] ASC_PFA = 8'h5D;
  localparam logic [7:0] ASC_SEEK_A = 8'h15;
  localparam logic [7:0] ASC_SEEK_B = 8'h02;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  localparam int ATTR_W = 2;

  typedef enum logic [1:0] {
    OFF_IDLE = 2'b00,
    OFF_WAIT = 2'b01,
    OFF_MEAS = 2'b10,
    OFF_SAVE = 2'b11
  } offState_t;

  typedef struct packed {
    logic valid;
    logic [ATTR_W-1:0] attr;
    logic err;
  } opEvt_t;

  typedef struct packed {
    logic valid;
    logic retried;
    logic eccOnly;
    logic unrecov;
    logic sameCause;
  } dataEvt_t;

  typedef struct packed {
    logic disparity;
    logic illegal;
    logic syncLoss;
    logic crc;
  } rxErr_t;

endpackage : pfm_pkg

// *** predictive_failure_monitor.sv ***
// Predictive failure monitor: per-attribute rate judging, history,
// off-line scheduler, error classing and an AHB-Lite register slave.
// Assumes all event inputs are synchronous to mclk.
//
// Overview of operation
// - Disable bit turns all monitoring off; error classing and its counters keep running
// - Enabled: gather attribute data during normal operations
// - On-line-only bit skips off-line measurement
// - Rezero measures, saves, restarts two-hour timer
// - Timer register reports time to next measurement
// - Measure and save every two hours when idle
// - Started off-line operation runs to completion
// - Delay bounded 42 ms or 163 ms
// - Report failure sense code per reporting method
// - Pending failure code survives resets and power
// - Per-attribute interval counter counts operations
// - Per-attribute failure counter counts errors
// - Errors over threshold before expiry: unacceptable
// - Interval end clears both counters
// - History up on bad, down on good, floor zero
// - History at threshold signals predictive failure
// - Separate history counter per attribute
// - Recovered only when retries were used
// - Unrecoverable: medium key, repeats counted once
// - Seek error: recovery, then hardware-error code if recovery fails
// - Interface error on four receiver conditions
//
// The AHB-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module predictive_failure_monitor
  import pfm_pkg::*;
#(
  parameter int NATTR = 4,
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int SCHED_LEN_MS = SCHED_MS,
  parameter logic [NATTR*16-1:0] INTV_LEN = {NATTR{16'h0064}},
  parameter logic [NATTR*8-1:0] ERR_THR = {NATTR{8'h05}},
  parameter logic [NATTR*8-1:0] PRED_THR = {NATTR{8'h04}}
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Drive events
  input wire opEvt_t opEvt,
  input wire dataEvt_t dataEvt,
  input wire logic seekErr,
  input wire logic seekRecovDone,
  input wire logic seekRecovOk,
  input wire logic seekCodeSel,
  input wire rxErr_t rxErr,
  input wire logic hostIdle,
  // Off-line engine handshake
  input wire logic measureDone,
  input wire logic saveDone,
  output logic measureReq,
  output logic saveReq,
  // Persistent pending code
  input wire logic nvPendIn,
  input wire logic [ATTR_W-1:0] nvAttrIn,
  output logic pendingOut,
  output logic [ATTR_W-1:0] pendAttrOut,
  // Status to the drive
  output logic recovReq,
  output logic ifaceErr,
  output logic reportReq
);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [7:0] ctrl_reg;
  logic wrPend_reg;
  logic [7:0] wrAddr_reg;
  logic addrOk;
  logic rdOk;
  logic monOn;
  logic onlineOnly;
  logic [3:0] method;
  logic ctrlWr;
  logic cmdWr;
  logic rezero;
  logic ackWr;

  assign addrOk = hsel && hready && htrans[1];
  assign rdOk = addrOk && !hwrite;
  assign monOn = !ctrl_reg[CTRL_DEXC];
  assign onlineOnly = ctrl_reg[CTRL_ONLINE];
  assign method = ctrl_reg[CTRL_METHOD +: 4];
  assign ctrlWr = wrPend_reg && (wrAddr_reg == A_CTRL);
  assign cmdWr = wrPend_reg && (wrAddr_reg == A_CMD);
  assign rezero = cmdWr && hwdata[CMD_RZ];
  assign ackWr = cmdWr && hwdata[CMD_ACK];

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wrPend_reg <= addrOk && hwrite;
      wrAddr_reg <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= CTRL_RST;
    end else if (ctrlWr) begin
      ctrl_reg <= hwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Per-attribute interval, failure and history counters
  // ----------------------------------------------------------------
  logic [NATTR-1:0] predHit;
  logic [31:0] histAll;

  for (genvar a = 0; a < NATTR; a++) begin : g_attr
    logic [15:0] intCnt_reg;
    logic [7:0] failCnt_reg;
    logic [7:0] hist_reg;
    logic [15:0] intNext;
    logic [7:0] failNext;
    logic hit;
    logic over;
    logic expire;

    assign hit = monOn && opEvt.valid && (opEvt.attr == ATTR_W'(a));
    assign intNext = intCnt_reg + 16'h0001;
    assign failNext = failCnt_reg + {7'h00, opEvt.err};
    assign over = failNext > ERR_THR[a*8 +: 8];
    assign expire = intNext >= INTV_LEN[a*16 +: 16];

    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        intCnt_reg <= 16'h0000;
        failCnt_reg <= 8'h00;
      end else if (!monOn) begin
        intCnt_reg <= 16'h0000;
        failCnt_reg <= 8'h00;
      end else if (hit) begin
        if (over || expire) begin
          intCnt_reg <= 16'h0000;
          failCnt_reg <= 8'h00;
        end else begin
          intCnt_reg <= intNext;
          failCnt_reg <= failNext;
        end
      end
    end

    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        hist_reg <= 8'h00;
      end else if (hit && over) begin
        if (hist_reg != 8'hFF) begin
          hist_reg <= hist_reg + 8'h01;
        end
      end else if (hit && expire && (hist_reg != 8'h00)) begin
        hist_reg <= hist_reg - 8'h01;
      end
    end

    assign predHit[a] = monOn && (hist_reg >= PRED_THR[a*8 +: 8]);
    assign histAll[a*8 +: 8] = hist_reg;
  end

  for (genvar b = NATTR; b < 4; b++) begin : g_pad
    assign histAll[b*8 +: 8] = 8'h00;
  end

  // ----------------------------------------------------------------
  // Pending predictive failure
  // ----------------------------------------------------------------
  function automatic logic [ATTR_W-1:0] firstSet(input logic [NATTR-1:0] v);
    logic [ATTR_W-1:0] idx;
    idx = '0;
    for (int i = NATTR - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = ATTR_W'(i);
      end
    end
    return idx;
  endfunction : firstSet

  logic started_reg;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      started_reg <= 1'b0;
      pendingOut <= 1'b0;
      pendAttrOut <= '0;
    end else begin
      started_reg <= 1'b1;
      if (!started_reg && nvPendIn) begin
        pendingOut <= 1'b1;
        pendAttrOut <= nvAttrIn;
      end else if (|predHit) begin
        pendingOut <= 1'b1;
        if (!pendingOut) begin
          pendAttrOut <= firstSet(predHit);
        end
      end else if (ackWr) begin
        pendingOut <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reportReq <= 1'b0;
    end else begin
      reportReq <= pendingOut && monOn && (method != 4'h0);
    end
  end

  // ----------------------------------------------------------------
  // Off-line scheduler
  // ----------------------------------------------------------------
  offState_t st_reg;
  offState_t stNext;
  logic [15:0] preCnt_reg;
  logic [23:0] schedCnt_reg;
  logic [7:0] busyMs_reg;
  logic [7:0] limit_reg;
  logic tick;
  logic schedDue;
  logic rezeroOk;
  logic timeUp;
  logic busy;

  assign tick = (preCnt_reg == 16'h0000);
  assign schedDue = (schedCnt_reg == 24'h000000);
  assign rezeroOk = rezero && monOn && !busy;
  assign timeUp = busyMs_reg >= limit_reg;
  assign busy = (st_reg == OFF_MEAS) || (st_reg == OFF_SAVE);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      preCnt_reg <= 16'h0000;
    end else if (tick) begin
      preCnt_reg <= 16'(TICK_CYC - 1);
    end else begin
      preCnt_reg <= preCnt_reg - 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      schedCnt_reg <= 24'(SCHED_LEN_MS);
    end else if (monOn && (rezeroOk || schedDue)) begin
      schedCnt_reg <= 24'(SCHED_LEN_MS);
    end else if (monOn && tick) begin
      schedCnt_reg <= schedCnt_reg - 24'h000001;
    end
  end

  always_comb begin
    stNext = st_reg;
    case (st_reg)
      OFF_IDLE: begin
        if (rezeroOk) begin
          stNext = onlineOnly ? OFF_SAVE : OFF_MEAS;
        end else if (monOn && schedDue && !onlineOnly) begin
          stNext = OFF_WAIT;
        end
      end
      OFF_WAIT: begin
        if (!monOn || onlineOnly) begin
          stNext = OFF_IDLE;
        end else if (hostIdle || rezeroOk) begin
          stNext = OFF_MEAS;
        end
      end
      OFF_MEAS: begin
        if (measureDone || timeUp) begin
          stNext = OFF_SAVE;
        end
      end
      OFF_SAVE: begin
        if (saveDone || timeUp) begin
          stNext = OFF_IDLE;
        end
      end
      default: begin
        stNext = OFF_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= OFF_IDLE;
      measureReq <= 1'b0;
      saveReq <= 1'b0;
    end else begin
      st_reg <= stNext;
      measureReq <= (stNext == OFF_MEAS);
      saveReq <= (stNext == OFF_SAVE);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      busyMs_reg <= 8'h00;
      limit_reg <= FULL_LIMIT;
    end else if (!busy) begin
      busyMs_reg <= 8'h00;
      limit_reg <= onlineOnly ? ONLINE_LIMIT : FULL_LIMIT;
    end else if (tick && !timeUp) begin
      busyMs_reg <= busyMs_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Error classing and sense data
  // ----------------------------------------------------------------
  logic [7:0] recCnt_reg;
  logic [7:0] unrecCnt_reg;
  logic [7:0] seekCnt_reg;
  logic [7:0] ifCnt_reg;
  logic [7:0] senseKey_reg;
  logic [7:0] senseAsc_reg;
  logic recovOk;
  logic unrecNew;
  logic seekFail;

  assign recovOk = dataEvt.valid && dataEvt.retried && !dataEvt.unrecov;
  assign unrecNew = dataEvt.valid && dataEvt.unrecov && !dataEvt.sameCause;
  assign seekFail = recovReq && seekRecovDone && !seekRecovOk;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      recCnt_reg <= 8'h00;
      unrecCnt_reg <= 8'h00;
      seekCnt_reg <= 8'h00;
      ifCnt_reg <= 8'h00;
    end else begin
      if (recovOk && (recCnt_reg != 8'hFF)) begin
        recCnt_reg <= recCnt_reg + 8'h01;
      end
      if (unrecNew && (unrecCnt_reg != 8'hFF)) begin
        unrecCnt_reg <= unrecCnt_reg + 8'h01;
      end
      if (seekFail && (seekCnt_reg != 8'hFF)) begin
        seekCnt_reg <= seekCnt_reg + 8'h01;
      end
      if (ifaceErr && (ifCnt_reg != 8'hFF)) begin
        ifCnt_reg <= ifCnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      recovReq <= 1'b0;
    end else if (seekErr) begin
      recovReq <= 1'b1;
    end else if (seekRecovDone) begin
      recovReq <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      senseKey_reg <= 8'h00;
      senseAsc_reg <= 8'h00;
    end else if (seekFail) begin
      senseKey_reg <= SK_HW;
      senseAsc_reg <= seekCodeSel ? ASC_SEEK_B : ASC_SEEK_A;
    end else if (unrecNew) begin
      senseKey_reg <= SK_MEDIUM;
      senseAsc_reg <= 8'h00;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ifaceErr <= 1'b0;
    end else begin
      ifaceErr <= rxErr.disparity || rxErr.illegal || rxErr.syncLoss || rxErr.crc;
    end
  end

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  function automatic logic [31:0] readMux(input logic [7:0] addr);
    logic [31:0] d;
    d = 32'h00000000;
    case (addr)
      A_CTRL: d = {24'h000000, ctrl_reg};
      A_STATUS: begin
        d = {16'h0000, 8'(predHit), 3'h0, busy, pendAttrOut, recovReq, pendingOut};
      end
      A_TIMER: d = {LOG_TIMER_PAGE, schedCnt_reg};
      A_SENSE: begin
        if (pendingOut && (method != 4'h0)) begin
          d = {8'h00, SK_RECOVERED, ASC_PFA, 6'h00, pendAttrOut};
        end else begin
          d = {8'h00, senseKey_reg, senseAsc_reg, 8'h00};
        end
      end
      A_ERRCNT: d = {ifCnt_reg, seekCnt_reg, unrecCnt_reg, recCnt_reg};
      A_HIST: d = histAll;
      default: d = 32'h00000000;
    endcase
    return d;
  endfunction : readMux

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h00000000;
    end else if (rdOk) begin
      hrdata <= readMux(haddr[7:0]);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  sequence sWaitIdle;
    (st_reg == OFF_WAIT) && hostIdle && monOn && !onlineOnly;
  endsequence

  sequence sOverBusy;
    busy && timeUp;
  endsequence

  chk_disable_clear: assert property (!monOn |=> (g_attr[0].intCnt_reg == 16'h0000))
    else $error("counters not cleared while disabled");
  chk_online_nomeas: assert property ((st_reg == OFF_IDLE) && onlineOnly |=> !measureReq)
    else $error("measurement started in on-line-only mode");
  chk_rezero_reload: assert property (rezeroOk |=> (schedCnt_reg == 24'(SCHED_LEN_MS)))
    else $error("rezero did not reload timer");
  chk_sched_idle: assert property (sWaitIdle |=> measureReq)
    else $error("idle period did not start measurement");
  chk_busy_bound: assert property (sOverBusy |-> ##[1:2] (st_reg == OFF_IDLE))
    else $error("off-line work overran its delay bound");
  chk_pend_hold: assert property (pendingOut && !ackWr |=> pendingOut)
    else $error("pending failure lost");
  chk_hist_up: assert property (g_attr[0].hit && g_attr[0].over
      && (g_attr[0].hist_reg != 8'hFF)
      |=> (g_attr[0].hist_reg == $past(g_attr[0].hist_reg) + 8'h01))
    else $error("history not incremented");
  chk_hist_floor: assert property ((g_attr[0].hist_reg == 8'h00) && !g_attr[0].over
      |=> (g_attr[0].hist_reg != 8'hFF))
    else $error("history went below zero");
  chk_pred_pend: assert property (predHit[0] |=> pendingOut ##1 reportReq || (method == 4'h0))
    else $error("predictive failure not signalled");
  chk_recov_retry: assert property (dataEvt.valid && !dataEvt.retried
      |=> (recCnt_reg == $past(recCnt_reg)))
    else $error("correction alone counted as recovered");
  chk_seek_key: assert property (seekFail |=> (senseKey_reg == SK_HW))
    else $error("seek failure key missing");
  chk_iface_flag: assert property ((rxErr != 4'h0) |=> ifaceErr)
    else $error("interface error not flagged");

endmodule : predictive_failure_monitor

`default_nettype wire

// *** offline_engine.sv ***
// Behavioural model of the off-line measure and save engine.
// Assumes level requests synchronous to mclk; stall holds back done.
`timescale 1ns/100ps
`default_nettype none

module offline_engine (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Requests and control
  input wire logic measureReq,
  input wire logic saveReq,
  input wire logic stall,
  // Done pulses
  output logic measureDone,
  output logic saveDone
);
  logic [3:0] waitCnt;

  // One done pulse after sixteen busy cycles, none while stalled
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      waitCnt <= 4'h0;
      measureDone <= 1'b0;
      saveDone <= 1'b0;
    end else begin
      measureDone <= 1'b0;
      saveDone <= 1'b0;
      if ((measureReq || saveReq) && !stall && !measureDone && !saveDone) begin
        waitCnt <= waitCnt + 4'h1;
        if (waitCnt == 4'hF) begin
          measureDone <= measureReq;
          saveDone <= saveReq && !measureReq;
        end
      end else begin
        waitCnt <= 4'h0;
      end
    end
  end
endmodule : offline_engine

`default_nettype wire

// *** test_predictive_failure_monitor.sv ***
// Self-checking bench for the failure monitor.
// Assumes the off-line engine model and shortened ticks and schedule.
`timescale 1ns/100ps
`default_nettype none

module test_predictive_failure_monitor
  import pfm_pkg::*;
;
  // ----------
  // Signals
  // ----------
  logic mclk, resetn, hsel, hwrite, hready, hreadyout, hresp, stall;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, nvAttrIn, pendAttrOut;
  logic [2:0] hsize;
  opEvt_t opEvt;
  dataEvt_t dataEvt;
  rxErr_t rxErr;
  logic seekErr, seekRecovDone, seekRecovOk, seekCodeSel, hostIdle;
  logic measureDone, saveDone, measureReq, saveReq, nvPendIn, pendingOut;
  logic recovReq, ifaceErr, reportReq;
  int errors = 0;
  int checks = 0;
  int cyc = 0;

  assign hready = hreadyout;

  predictive_failure_monitor #(.TICK_CYC(4), .SCHED_LEN_MS(20),
    .INTV_LEN({4{16'h0008}}), .ERR_THR({4{8'h02}}), .PRED_THR({4{8'h02}})) uut (
    .mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .opEvt(opEvt),
    .dataEvt(dataEvt), .seekErr(seekErr), .seekRecovDone(seekRecovDone),
    .seekRecovOk(seekRecovOk), .seekCodeSel(seekCodeSel), .rxErr(rxErr),
    .hostIdle(hostIdle), .measureDone(measureDone), .saveDone(saveDone),
    .measureReq(measureReq), .saveReq(saveReq), .nvPendIn(nvPendIn),
    .nvAttrIn(nvAttrIn), .pendingOut(pendingOut), .pendAttrOut(pendAttrOut),
    .recovReq(recovReq), .ifaceErr(ifaceErr), .reportReq(reportReq));

  offline_engine eng (.mclk(mclk), .resetn(resetn), .measureReq(measureReq),
    .saveReq(saveReq), .stall(stall), .measureDone(measureDone), .saveDone(saveDone));

  // ----------
  // Tasks
  // ----------
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    cmp(q, e);
  endtask : rdc

  task automatic op(input logic [1:0] a, input logic e, input int n);
    @(posedge mclk);
    repeat (n) begin
      opEvt <= '{1'b1, a, e};
      @(posedge mclk);
    end
    opEvt <= '0;
  endtask : op

  task automatic pulse(input dataEvt_t d, input rxErr_t r);
    @(posedge mclk);
    dataEvt <= d; rxErr <= r;
    @(posedge mclk);
    dataEvt <= '0; rxErr <= '0;
    @(negedge mclk);
  endtask : pulse

  task automatic do_reset(input int n);
    resetn <= 1'b0;
    repeat (n) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
  endtask : do_reset

  task automatic busy_len(output int n);
    n = 0;
    @(negedge mclk);
    while ((measureReq === 1'b1 || saveReq === 1'b1) && n < 2000) begin
      @(negedge mclk);
      n++;
    end
  endtask : busy_len

  task automatic watch(input int n, output logic s);
    s = 1'b0;
    repeat (n) begin
      @(negedge mclk);
      s = s | measureReq;
    end
  endtask : watch

  task automatic rezero(input logic [31:0] ctrl);
    wr(A_CTRL, ctrl);
    wr(A_CMD, 32'h1);
    @(negedge mclk);
  endtask : rezero

  // ----------
  // Tests
  // ----------
  task automatic t_hist;
    rdc(A_CTRL, 32'h0);
    rdc(8'h1C, 32'h0);
    cmp({hreadyout, hresp}, 32'h2);
    op(2'h1, 1'b1, 3);
    rdc(A_HIST, 32'h0000_0100);
    op(2'h1, 1'b1, 2);
    op(2'h1, 1'b0, 5);
    rdc(A_HIST, 32'h0000_0100);
    op(2'h1, 1'b0, 1);
    rdc(A_HIST, 32'h0);
    op(2'h0, 1'b0, 8);
    op(2'h3, 1'b1, 3);
    rdc(A_HIST, 32'h0100_0000);
    $display("history test done");
  endtask : t_hist

  task automatic t_pred;
    do_reset(2);
    wr(A_CTRL, 32'h10);
    op(2'h0, 1'b1, 6);
    rdc(A_HIST, 32'h0000_0002);
    rdc(A_STATUS, 32'h0000_0101);
    cmp(reportReq, 1'b1);
    rdc(A_SENSE, {8'h00, SK_RECOVERED, ASC_PFA, 8'h00});
    nvPendIn <= 1'b1; nvAttrIn <= 2'h2;
    do_reset(3);
    nvPendIn <= 1'b0;
    cmp({pendingOut, pendAttrOut}, 3'b110);
    wr(A_CMD, 32'h2);
    @(negedge mclk);
    cmp(pendingOut, 1'b0);
    $display("predictive test done");
  endtask : t_pred

  task automatic t_dis;
    wr(A_CTRL, 32'h1);
    op(2'h0, 1'b1, 9);
    rdc(A_HIST, 32'h0);
    wr(A_CMD, 32'h1);
    @(negedge mclk);
    cmp(measureReq, 1'b0);
    wr(A_CTRL, 32'h0);
    $display("disable test done");
  endtask : t_dis

  task automatic t_err;
    pulse(5'b11000, '0);
    pulse(5'b10100, '0);
    pulse(5'b10010, '0);
    pulse(5'b10011, '0);
    rdc(A_ERRCNT, 32'h0000_0101);
    rdc(A_SENSE, {8'h00, SK_MEDIUM, 16'h0});
    for (int s = 0; s < 2; s++) begin
      @(posedge mclk); seekErr <= 1'b1;
      @(posedge mclk); seekErr <= 1'b0;
      @(negedge mclk); cmp(recovReq, 1'b1);
      @(posedge mclk); seekRecovDone <= 1'b1; seekRecovOk <= 1'b0; seekCodeSel <= s[0];
      @(posedge mclk); seekRecovDone <= 1'b0;
      @(negedge mclk); cmp(recovReq, 1'b0);
      rdc(A_SENSE, {8'h00, SK_HW, s ? ASC_SEEK_B : ASC_SEEK_A, 8'h00});
    end
    for (int i = 0; i < 4; i++) begin
      pulse('0, 4'(1 << i));
      cmp(ifaceErr, 1'b1);
    end
    rdc(A_ERRCNT, 32'h0402_0101);
    $display("error class test done");
  endtask : t_err

  task automatic t_rezero;
    int n;
    logic [31:0] q;
    stall <= 1'b1;
    rezero(32'h2);
    cmp({measureReq, saveReq}, 2'b01);
    busy_len(n);
    cmp(n >= 156 && n <= 172, 1'b1);
    rezero(32'h0);
    cmp(measureReq, 1'b1);
    busy_len(n);
    cmp(n >= 640 && n <= 660, 1'b1);
    stall <= 1'b0;
    rezero(32'h0);
    bus(A_TIMER, 1'b0, 32'h0, q);
    cmp(q[31:24], LOG_TIMER_PAGE);
    cmp(q[23:0] >= 24'd18 && q[23:0] <= 24'd20, 1'b1);
    wr(A_CTRL, 32'h1);
    @(negedge mclk);
    cmp(measureReq, 1'b1);
    n = 0;
    while (measureReq === 1'b1 && n++ < 100) @(negedge mclk);
    cmp(saveReq, 1'b1);
    busy_len(n);
    wr(A_CTRL, 32'h0);
    $display("rezero test done");
  endtask : t_rezero

  task automatic t_sched;
    int n;
    logic s;
    rezero(32'h0);
    busy_len(n);
    watch(120, s);
    cmp(s, 1'b0);
    @(posedge mclk); hostIdle <= 1'b1;
    watch(10, s);
    cmp(s, 1'b1);
    busy_len(n);
    wr(A_CTRL, 32'h2);
    watch(200, s);
    cmp(s, 1'b0);
    $display("schedule test done");
  endtask : t_sched

  // ----------
  // Main
  // ----------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      end_sim();
    end
  end

  initial begin
    resetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; opEvt = '0; dataEvt = '0; rxErr = '0;
    seekErr = 1'b0; seekRecovDone = 1'b0; seekRecovOk = 1'b0; seekCodeSel = 1'b0;
    hostIdle = 1'b0; nvPendIn = 1'b0; nvAttrIn = 2'h0; stall = 1'b0;
    do_reset(20);
    t_hist();
    t_pred();
    t_dis();
    t_err();
    t_rezero();
    t_sched();
    end_sim();
  end
endmodule : test_predictive_failure_monitor

`default_nettype wire
